// >>> logic/adc_dma_params.svh
// constants for the adc result dma and its event logic
// assumes inclusion by bare name from the design modules and the testbench
`ifndef ADC_DMA_PARAMS_SVH
`define ADC_DMA_PARAMS_SVH

// register byte addresses
`define OFS_EVENT_FLAGS    16'hA810
`define OFS_EVENT_ENABLES  16'hA850
`define OFS_DMA_CONFIG     16'hD010
`define OFS_DMA_STATUS     16'hD014
`define OFS_BUFFER_START   16'hD018
`define OFS_BUFFER_LENGTH  16'hD01C
`define OFS_WRITE_POINTER  16'hD020
`define OFS_RESULT_COUNT   16'hD024
`define OFS_TOP_ENABLE     16'hD028

// reset values
`define RST_BUFFER_START   32'h2000_0000
`define RST_ZERO           32'h0000_0000

// field positions
`define BIT_EV_OVERFLOW    4
`define BIT_EV_SATURATE    3
`define BIT_EV_FULL        2
`define BIT_EV_HALF        1
`define BIT_CFG_RESET      4
`define BIT_CFG_WRAP       1
`define BIT_CFG_LOAD       0
`define BIT_ST_OVERRUN     1
`define BIT_ST_ACTIVE      0
`define ADDR_MSB           13
`define LEN_MSB            12

// axi response codes
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// >>> logic/adc_dma_pkg.sv
// types for the adc result dma
// assumes adc_dma_params.svh sits on the include path
package adc_dma_pkg;
    // one result from the conversion engine
    typedef struct packed {
        logic        valid;      // result ready this cycle
        logic        saturated;  // gain correction clipped
        logic [15:0] data;       // corrected result
    } result_type;

    // one ram write request
    typedef struct packed {
        logic        we;         // write strobe
        logic [13:0] addr;       // byte address
        logic [15:0] data;       // halfword data
    } ram_wr_type;

    // transfer state
    typedef enum logic [0:0] {
        XFER_IDLE,
        XFER_RUN
    } xfer_state_type;
endpackage

// >>> logic/adc_event_unit.sv
// sticky event flags, enables and the merged interrupt
// assumes single clock, events are one-cycle pulses from the dma
`timescale 1ns/1ps
`include "adc_dma_params.svh"
module adc_event_unit (
    input  wire logic       aclk,        // system clock
    input  wire logic       aresetn,     // sync reset, active low
    input  wire logic [4:0] event_set,   // event pulses at flag positions
    input  wire logic [4:0] clear_mask,  // write-one-to-clear strobe
    input  wire logic [4:0] enable_bits, // per-source enables
    input  wire logic       top_enable,  // top-level gate on the merged interrupt
    output logic      [4:0] flags,       // sticky pending flags
    output logic            irq          // merged interrupt level
);
    ////////////////////////////////////////////////////////////////////////////
    // flags: set wins over a clear in the same cycle, bit0 never stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags <= 5'h00;
        else
            flags <= ((flags & ~clear_mask) | event_set) & 5'h1E;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered interrupt so the top output is a flop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= top_enable && |(flags & enable_bits & 5'h1E);
    end

    AST_IRQ_NEEDS_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        irq |-> $past(top_enable) && |($past(flags) & $past(enable_bits)))
        else $error("interrupt without enabled pending flag");

    AST_W1C_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
        (clear_mask[`BIT_EV_FULL] && !event_set[`BIT_EV_FULL])
        |=> !flags[`BIT_EV_FULL])
        else $error("full flag not cleared by write one");

    AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
        event_set[`BIT_EV_OVERFLOW] |=> flags[`BIT_EV_OVERFLOW])
        else $error("overflow event lost");

    AST_SAT_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
        event_set[`BIT_EV_SATURATE] |=> flags[`BIT_EV_SATURATE])
        else $error("saturation event lost");
endmodule // adc_event_unit

// >>> logic/adc_result_dma.sv
// adc result buffer dma with axi4-lite registers and event logic
// assumes results arrive as one-cycle pulses; ram write takes one cycle
`timescale 1ns/1ps
`include "adc_dma_params.svh"
module adc_result_dma (
    input  wire logic                    aclk,       // system clock
    input  wire logic                    aresetn,    // sync reset, active low
    // axi4-lite slave
    input  wire logic [15:0]             awaddr,     // write address
    input  wire logic                    awvalid,    // write address valid
    output logic                         awready,    // write address ready
    input  wire logic [31:0]             wdata,      // write data
    input  wire logic [3:0]              wstrb,      // byte enables
    input  wire logic                    wvalid,     // write data valid
    output logic                         wready,     // write data ready
    output logic [1:0]                   bresp,      // write response
    output logic                         bvalid,     // write response valid
    input  wire logic                    bready,     // write response ready
    input  wire logic [15:0]             araddr,     // read address
    input  wire logic                    arvalid,    // read address valid
    output logic                         arready,    // read address ready
    output logic [31:0]                  rdata,      // read data
    output logic [1:0]                   rresp,      // read response
    output logic                         rvalid,     // read data valid
    input  wire logic                    rready,     // read data ready
    // conversion engine and ram
    input  wire adc_dma_pkg::result_type result_in,  // result stream
    output adc_dma_pkg::ram_wr_type      ram_wr_ff,  // ram write port
    output logic                         irq_ff      // merged interrupt
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [13:0] start_ff;       // buffer start, bit0 zero
    logic [12:0] length_ff;      // length in entries
    logic [13:1] cur_ff;         // next halfword address
    logic [12:0] count_ff;       // stored results
    logic        wrap_ff;        // wrap mode select
    logic        overrun_ff;     // transfer overrun status
    logic [4:0]  enables_ff;     // event enables
    logic        top_en_ff;      // top-level gate on the merged interrupt
    adc_dma_pkg::xfer_state_type state_ff; // transfer state
    logic [4:0]  flags;          // sticky flags from event unit
    logic        irq;            // merged interrupt from event unit

    // write channel latches
    logic        aw_hold_ff;     // address taken
    logic        w_hold_ff;      // data taken
    logic [15:0] waddr_ff;       // latched address
    logic [31:0] wdata_ff;       // latched data
    logic [3:0]  wstrb_ff;       // latched strobes

    // decoded strobes
    logic        wr_go;          // both halves present
    logic [4:0]  nxt_clear;      // flag clear mask
    logic [4:0]  nxt_events;     // event pulses
    logic        cfg_load;       // load strobe
    logic        cfg_reset;      // dma reset strobe
    logic        store;          // result accepted

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a[15:2] == ofs[15:2]);
    endfunction

    assign wr_go     = aw_hold_ff && w_hold_ff && !bvalid;
    assign cfg_load  = wr_go && hit(waddr_ff, `OFS_DMA_CONFIG) && wstrb_ff[0]
                       && wdata_ff[`BIT_CFG_LOAD];
    assign cfg_reset = wr_go && hit(waddr_ff, `OFS_DMA_CONFIG) && wstrb_ff[0]
                       && wdata_ff[`BIT_CFG_RESET];
    assign nxt_clear = (wr_go && hit(waddr_ff, `OFS_EVENT_FLAGS) && wstrb_ff[0])
                       ? wdata_ff[4:0] : 5'h00;
    assign store     = result_in.valid && state_ff == adc_dma_pkg::XFER_RUN;

    ////////////////////////////////////////////////////////////////////////////
    // axi write channel: address and data taken in either order
    // ready flops mirror an empty slot, so every bus output is a register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            waddr_ff   <= 16'h0000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            awready    <= 1'b1;
            wready     <= 1'b1;
            bvalid     <= 1'b0;
            bresp      <= `RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_hold_ff <= 1'b1;
                awready    <= 1'b0;
                waddr_ff   <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_hold_ff <= 1'b1;
                wready    <= 1'b0;
                wdata_ff  <= wdata;
                wstrb_ff  <= wstrb;
            end
            if (wr_go)
            begin
                // commit and answer
                aw_hold_ff <= 1'b0;
                w_hold_ff  <= 1'b0;
                awready    <= 1'b1;
                wready     <= 1'b1;
                bvalid     <= 1'b1;
                bresp      <= (hit(waddr_ff, `OFS_EVENT_FLAGS) || hit(waddr_ff, `OFS_EVENT_ENABLES)
                    || hit(waddr_ff, `OFS_DMA_CONFIG) || hit(waddr_ff, `OFS_BUFFER_START)
                    || hit(waddr_ff, `OFS_BUFFER_LENGTH) || hit(waddr_ff, `OFS_TOP_ENABLE)
                    || hit(waddr_ff, `OFS_DMA_STATUS) || hit(waddr_ff, `OFS_WRITE_POINTER)
                    || hit(waddr_ff, `OFS_RESULT_COUNT)) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-written configuration
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_ff   <= 14'(`RST_BUFFER_START);
            length_ff  <= 13'h0000;
            wrap_ff    <= 1'b0;
            enables_ff <= 5'h00;
            top_en_ff  <= 1'b0;
        end
        else if (wr_go && wstrb_ff[0])
        begin
            if (hit(waddr_ff, `OFS_BUFFER_START))
                start_ff <= {wdata_ff[13:1], 1'b0};
            if (hit(waddr_ff, `OFS_BUFFER_LENGTH))
                length_ff <= wdata_ff[12:0];
            if (hit(waddr_ff, `OFS_DMA_CONFIG))
                wrap_ff <= wdata_ff[`BIT_CFG_WRAP];
            if (hit(waddr_ff, `OFS_EVENT_ENABLES))
                enables_ff <= wdata_ff[4:0] & 5'h1E;
            if (hit(waddr_ff, `OFS_TOP_ENABLE))
                top_en_ff <= wdata_ff[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer engine: pointer, counter, mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff   <= adc_dma_pkg::XFER_IDLE;
            cur_ff     <= 13'h0000;
            count_ff   <= 13'h0000;
            overrun_ff <= 1'b0;
            ram_wr_ff  <= '0;
        end
        else
        begin
            ram_wr_ff.we <= 1'b0;
            if (cfg_reset)
            begin
                state_ff   <= adc_dma_pkg::XFER_IDLE;
                overrun_ff <= 1'b0;
            end
            else if (cfg_load)
            begin
                state_ff <= adc_dma_pkg::XFER_RUN;
                cur_ff   <= start_ff[13:1];
                count_ff <= 13'h0000;
            end
            else
            begin
                if (result_in.valid && state_ff != adc_dma_pkg::XFER_RUN)
                    overrun_ff <= 1'b1;
                case (state_ff)
                    adc_dma_pkg::XFER_IDLE: ;
                    adc_dma_pkg::XFER_RUN:
                        if (store)
                        begin
                            ram_wr_ff.we   <= 1'b1;
                            ram_wr_ff.addr <= {cur_ff, 1'b0};
                            ram_wr_ff.data <= result_in.data;
                            count_ff       <= count_ff + 13'h0001;
                            if (count_ff + 13'h0001 >= length_ff)
                            begin
                                if (wrap_ff)
                                begin
                                    cur_ff   <= start_ff[13:1];
                                    count_ff <= 13'h0000;
                                end
                                else
                                    state_ff <= adc_dma_pkg::XFER_IDLE;
                            end
                            else
                                cur_ff <= cur_ff + 13'h0001;
                        end
                    default: state_ff <= adc_dma_pkg::XFER_IDLE;
                endcase
            end
        end
    end

    // event pulses; half and full compare the count after this store
    always_comb
    begin
        nxt_events = 5'h00;
        nxt_events[`BIT_EV_OVERFLOW] = result_in.valid && !store;
        nxt_events[`BIT_EV_SATURATE] = result_in.valid && result_in.saturated;
        nxt_events[`BIT_EV_FULL] = store && (count_ff + 13'h0001 == length_ff);
        nxt_events[`BIT_EV_HALF] = store
            && (count_ff + 13'h0001 == {1'b0, length_ff[12:1]});
    end

    ////////////////////////////////////////////////////////////////////////////
    // event flags and interrupt merge
    adc_event_unit u_events (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .event_set   (nxt_events),
        .clear_mask  (nxt_clear),
        .enable_bits (enables_ff),
        .top_enable  (top_en_ff),
        .flags       (flags),
        .irq         (irq)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= irq;
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi read channel, one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid  <= 1'b1;
            arready <= 1'b0;
            rresp  <= `RESP_OKAY;
            if (hit(araddr, `OFS_EVENT_FLAGS))
                rdata <= {27'h0, flags};
            else if (hit(araddr, `OFS_EVENT_ENABLES))
                rdata <= {27'h0, enables_ff};
            else if (hit(araddr, `OFS_DMA_CONFIG))
                rdata <= {30'h0, wrap_ff, 1'b0};
            else if (hit(araddr, `OFS_DMA_STATUS))
                rdata <= {30'h0, overrun_ff, state_ff == adc_dma_pkg::XFER_RUN};
            else if (hit(araddr, `OFS_BUFFER_START))
                rdata <= {18'h0, start_ff};
            else if (hit(araddr, `OFS_BUFFER_LENGTH))
                rdata <= {19'h0, length_ff};
            else if (hit(araddr, `OFS_WRITE_POINTER))
                rdata <= {18'h0, cur_ff, 1'b0};
            else if (hit(araddr, `OFS_RESULT_COUNT))
                rdata <= {19'h0, count_ff};
            else if (hit(araddr, `OFS_TOP_ENABLE))
                rdata <= {31'h0, top_en_ff};
            else
            begin
                rdata <= 32'h0000_0000;
                rresp <= `RESP_SLVERR;
            end
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_LINEAR_STOPS: assert property (@(posedge aclk) disable iff (!aresetn)
        (store && !wrap_ff && count_ff + 13'h0001 >= length_ff && !cfg_load && !cfg_reset)
        |=> state_ff == adc_dma_pkg::XFER_IDLE)
        else $error("linear transfer did not stop when full");

    AST_ADVANCE: assert property (@(posedge aclk) disable iff (!aresetn)
        (store && count_ff + 13'h0001 < length_ff && !cfg_load && !cfg_reset)
        |=> cur_ff == $past(cur_ff) + 13'h0001 && count_ff == $past(count_ff) + 13'h0001)
        else $error("pointer or count did not advance");

    AST_START_EVEN: assert property (@(posedge aclk) disable iff (!aresetn)
        !start_ff[0])
        else $error("buffer start odd");

    AST_FULL_EVENT: assert property (@(posedge aclk) disable iff (!aresetn)
        (store && count_ff + 13'h0001 == length_ff) |=> flags[`BIT_EV_FULL])
        else $error("full flag not raised");

    AST_HALF_EVENT: assert property (@(posedge aclk) disable iff (!aresetn)
        (store && count_ff + 13'h0001 == {1'b0, length_ff[12:1]})
        |=> flags[`BIT_EV_HALF])
        else $error("half flag not raised");

    AST_OVF_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
        (result_in.valid && state_ff == adc_dma_pkg::XFER_IDLE)
        |=> flags[`BIT_EV_OVERFLOW])
        else $error("overflow not flagged when idle");
endmodule // adc_result_dma

// >>> bench/adc_partner_model.sv
// partner model: conversion engine result source and system ram
// assumes one clock shared with the dma; ram takes a write in one cycle
`timescale 1ns/1ps
module adc_partner_model (
    input  wire logic                    aclk,      // system clock
    output adc_dma_pkg::result_type      result_in, // result stream to dma
    input  wire adc_dma_pkg::ram_wr_type ram_wr_ff  // ram write port from dma
);
    logic [15:0] mem [0:8191]; // halfword ram image
    int          wr_count;     // ram writes seen

    ////////////////////////////////////////////////////////////////////////////
    // ram: one halfword per write, indexed by byte address bits 13:1
    initial wr_count = 0;
    always @(posedge aclk)
    begin
        if (ram_wr_ff.we)
        begin
            mem[ram_wr_ff.addr[13:1]] <= ram_wr_ff.data;
            wr_count                  <= wr_count + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // engine: n back-to-back results counting up from val, last may saturate
    initial result_in = '0;
    task automatic push(input int n, input logic [15:0] val, input logic sat_last);
        for (int i = 0; i < n; i++)
        begin
            @(posedge aclk);
            result_in <= '{1'b1, sat_last && (i == n - 1), val + 16'(i)};
        end
        @(posedge aclk);
        // stale data inverted so nobody can lean on a held value
        result_in <= '{1'b0, 1'b0, ~(val + 16'(n - 1))};
    endtask
endmodule // adc_partner_model

// >>> bench/tb_adc_result_dma_and_events.sv
// testbench for the adc result dma, its registers and its interrupt
// assumes the design header on the include path and the partner model beside
`timescale 1ns/1ps
`include "adc_dma_params.svh"
module tb_adc_result_dma_and_events;
    logic        aclk, aresetn;                      // clock and reset
    logic [15:0] awaddr, araddr;                     // bus addresses
    logic        awvalid, wvalid, bready, arvalid, rready; // master strobes
    logic        awready, wready, bvalid, arready, rvalid; // slave strobes
    logic [31:0] wdata, rdata, rd_data;              // bus data
    logic [3:0]  wstrb;                              // byte enables, all on
    logic [1:0]  bresp, rresp, rd_resp, last_bresp;  // responses
    logic        irq;                                // merged interrupt
    int          num_errors, n_tests, cycles;        // verdict and watchdog
    adc_dma_pkg::result_type result_in;              // engine to dma
    adc_dma_pkg::ram_wr_type ram_wr;                 // dma to ram

    ////////////////////////////////////////////////////////////////////////////
    // clock, reset and watchdog
    initial aclk = 1'b0;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            results();
        end
    end

    adc_result_dma dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .result_in(result_in), .ram_wr_ff(ram_wr), .irq_ff(irq)
    );
    adc_partner_model partner_u (.aclk(aclk), .result_in(result_in), .ram_wr_ff(ram_wr));

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers: compare, bus cycles, verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic w(input logic [15:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                last_bresp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    // read: data and response taken at the edge where rvalid is seen
    task automatic rd(input logic [15:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                rd_data = rdata;
                rd_resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rc(input logic [15:0] a, input logic [31:0] exp);
        rd(a);
        check(rd_data, exp);
    endtask

    task automatic results();
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    // reset values, read-only count, unmapped place both ways
    task automatic t_reset();
        rc(`OFS_BUFFER_START, `RST_BUFFER_START & 32'h0000_3FFF);
        rc(`OFS_WRITE_POINTER, `RST_BUFFER_START & 32'h0000_3FFE);
        rc(`OFS_EVENT_FLAGS, `RST_ZERO);
        rc(`OFS_EVENT_ENABLES, `RST_ZERO);
        rc(`OFS_BUFFER_LENGTH, `RST_ZERO);
        w(`OFS_RESULT_COUNT, 32'h0000_1234);
        rc(`OFS_RESULT_COUNT, `RST_ZERO);
        rd(16'h0004);
        check({30'h0, rd_resp}, {30'h0, `RESP_SLVERR});
        w(16'h0008, 32'hFFFF_FFFF);
        check({30'h0, last_bresp}, {30'h0, `RESP_SLVERR});
    endtask

    // field widths and the forced even start
    task automatic t_fields();
        w(`OFS_BUFFER_START, 32'hFFFF_FFFF);
        rc(`OFS_BUFFER_START, 32'h0000_3FFE);
        w(`OFS_BUFFER_LENGTH, 32'hFFFF_FFFF);
        rc(`OFS_BUFFER_LENGTH, 32'h0000_1FFF);
        w(`OFS_EVENT_ENABLES, 32'h0000_001E);
        rc(`OFS_EVENT_ENABLES, 32'h0000_001E);
    endtask

    // linear run of four entries, then a result with the transfer stopped
    task automatic t_linear();
        w(`OFS_BUFFER_START, 32'h0000_0100);
        w(`OFS_BUFFER_LENGTH, 32'h0000_0004);
        w(`OFS_TOP_ENABLE, 32'h0000_0001);
        w(`OFS_DMA_CONFIG, 32'h0000_0001);
        rc(`OFS_DMA_STATUS, 32'h0000_0001);
        rc(`OFS_WRITE_POINTER, 32'h0000_0100);
        partner_u.push(2, 16'hA000, 1'b0);
        rc(`OFS_RESULT_COUNT, 32'h0000_0002);
        rc(`OFS_WRITE_POINTER, 32'h0000_0104);
        rc(`OFS_EVENT_FLAGS, 32'h0000_0002);
        partner_u.push(2, 16'hA002, 1'b0);
        rc(`OFS_EVENT_FLAGS, 32'h0000_0006);
        rc(`OFS_DMA_STATUS, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
            check({16'h0, partner_u.mem[13'h0080 + 13'(i)]}, {16'h0, 16'hA000 + 16'(i)});
        partner_u.push(1, 16'hBEEF, 1'b0);
        rc(`OFS_EVENT_FLAGS, 32'h0000_0016);
        check(32'(partner_u.wr_count), 32'h0000_0004);
        rc(`OFS_DMA_STATUS, 32'h0000_0002);
    endtask

    // masking at both levels and write-one-to-clear
    task automatic t_irq();
        check({31'h0, irq}, 32'h0000_0001);
        w(`OFS_TOP_ENABLE, 32'h0000_0000);
        rc(`OFS_EVENT_FLAGS, 32'h0000_0016);
        check({31'h0, irq}, 32'h0000_0000);
        w(`OFS_TOP_ENABLE, 32'h0000_0001);
        w(`OFS_EVENT_ENABLES, 32'h0000_0008);
        rc(`OFS_EVENT_ENABLES, 32'h0000_0008);
        check({31'h0, irq}, 32'h0000_0000);
        w(`OFS_EVENT_ENABLES, 32'h0000_0010);
        w(`OFS_EVENT_FLAGS, 32'h0000_0001);
        rc(`OFS_EVENT_FLAGS, 32'h0000_0016);
        check({31'h0, irq}, 32'h0000_0001);
        w(`OFS_EVENT_FLAGS, 32'h0000_0011);
        rc(`OFS_EVENT_FLAGS, 32'h0000_0006);
        check({31'h0, irq}, 32'h0000_0000);
        w(`OFS_EVENT_FLAGS, 32'h0000_0007);
        rc(`OFS_EVENT_FLAGS, 32'h0000_0000);
    endtask

    // wrap mode over three entries, last one saturated
    task automatic t_wrap();
        w(`OFS_DMA_CONFIG, 32'h0000_0010);
        rc(`OFS_DMA_STATUS, 32'h0000_0000);
        w(`OFS_BUFFER_START, 32'h0000_0201);
        w(`OFS_BUFFER_LENGTH, 32'h0000_0003);
        w(`OFS_EVENT_ENABLES, 32'h0000_000E);
        w(`OFS_DMA_CONFIG, 32'h0000_0003);
        rc(`OFS_WRITE_POINTER, 32'h0000_0200);
        rc(`OFS_RESULT_COUNT, 32'h0000_0000);
        partner_u.push(3, 16'h5000, 1'b1);
        rc(`OFS_WRITE_POINTER, 32'h0000_0200);
        rc(`OFS_EVENT_FLAGS, 32'h0000_000E);
        rc(`OFS_DMA_STATUS, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
        partner_u.push(1, 16'h6000, 1'b0);
        rc(`OFS_WRITE_POINTER, 32'h0000_0202);
        check({16'h0, partner_u.mem[13'h0100]}, 32'h0000_6000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb      = 4'hF;
        aresetn    = 1'b0;
        num_errors = 0;
        n_tests    = 0;
        cycles     = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fields();
        t_linear();
        t_irq();
        t_wrap();
        results();
    end
endmodule // tb_adc_result_dma_and_events
